// ===== design/psc_host.sv
// Host controller that drives an asynchronous, page-capable pseudo-static memory.
// Assumes the memory pins are registered straight to the pads and read data is
// synchronous to mclk; the pad logic resolves the data lines from data_lines_oe_n.
//
// Summary of operation
// - Read: select, output enable, byte low, write high.
// - Write: select, write enable, byte low, sleep high.
// - Write enable low no longer than limit.
// - Chip select low no longer than limit.
// - Sleep low write loads config, data floats.
// - Keep select high during initialisation.
// - Low-power only after sleep low over 10 us.
`timescale 1ns/10ps
module psc_host
    import psc_pkg::*;
#(
    parameter logic [15:0] INIT_CYC = 16'(INIT_CYC_DEF)
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic req,
    input wire logic req_write,
    input wire logic [19:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic [1:0] req_bytes,
    output logic req_ready,
    output logic [15:0] rdata,
    output logic rdata_valid,
    output logic wr_done,
    input wire logic cfg_req,
    input wire logic [19:0] cfg_value,
    output logic [19:0] cfg_current,
    input wire logic sleep_req,
    output logic sleep_active,
    output logic init_busy,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic low_byte_select_n,
    output logic high_byte_select_n,
    output logic sleep_pin_n,
    output logic [19:0] address_lines,
    input wire logic [15:0] data_lines_in,
    output logic [15:0] data_lines_out,
    output logic data_lines_oe_n
);

    typedef struct packed {
        psc_state_t state;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic lb_n;
        logic ub_n;
        logic zz_n;
        logic [19:0] addr;
        logic [15:0] dout;
        logic doe_n;
        logic [15:0] rdata;
        logic rvalid;
        logic wdone;
        logic [19:0] cfg;
        logic [15:0] ce_cnt;
        logic [15:0] zz_cnt;
    } psc_host_st_t;

    localparam psc_host_st_t RESET_ST = '{state: S_INIT, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
        lb_n: 1'b1, ub_n: 1'b1, zz_n: 1'b1, addr: 20'h00000, dout: 16'h0000, doe_n: 1'b1,
        rdata: 16'h0000, rvalid: 1'b0, wdone: 1'b0, cfg: CFG_DEFAULT, ce_cnt: 16'h0000,
        zz_cnt: 16'h0000};

    psc_host_st_t s;
    psc_host_st_t next_s;
    logic t_load;
    logic [15:0] t_value;
    logic t_done;
    logic page_en;
    logic pg_take;

    // Saturating count of cycles a strobe has been low.
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction : sat_inc

    // =====================================================================
    // Phase timer
    // =====================================================================
    // Reset starts the power-up wait, so chip select stays high through it.
    psc_timer #(.START(INIT_CYC)) u_timer (
        .mclk(mclk),
        .srst(srst),
        .load(t_load),
        .load_value(t_value),
        .done(t_done)
    );

    // =====================================================================
    // Request acceptance
    // =====================================================================
    // Page reads only after the configuration enables them; default is off.
    assign page_en = s.cfg[CFG_PAGE_BIT];
    // Only a read in the same page continues; any higher bit change reopens the cycle.
    assign pg_take = (s.state == S_HOLD) && page_en && req && !req_write && !cfg_req && !sleep_req
        && (req_addr[19:PAGE_LSB] == s.addr[19:PAGE_LSB]) && (s.ce_cnt < HOLD_LIMIT);
    assign req_ready = ((s.state == S_IDLE) && !cfg_req && !sleep_req) || pg_take;

    // =====================================================================
    // Cycle sequencer
    // =====================================================================
    always_comb begin
        next_s = s;
        t_load = 1'b0;
        t_value = 16'h0000;
        next_s.rvalid = 1'b0;
        next_s.wdone = 1'b0;
        case (s.state)
            S_INIT: begin
                if (t_done) begin
                    next_s.state = S_IDLE;
                end
            end
            S_IDLE: begin
                if (cfg_req) begin
                    next_s.zz_n = 1'b0;
                    next_s.addr = cfg_value;
                    t_load = 1'b1;
                    t_value = SETUP_CYC;
                    next_s.state = S_CFG_ZZ;
                end else if (sleep_req) begin
                    next_s.zz_n = 1'b0;
                    t_load = 1'b1;
                    t_value = SLEEP_CYC;
                    next_s.state = S_SLP_IN;
                end else if (req) begin
                    next_s.addr = req_addr;
                    next_s.lb_n = !req_bytes[0];
                    next_s.ub_n = !req_bytes[1];
                    next_s.ce_n = 1'b0;
                    t_load = 1'b1;
                    if (req_write) begin
                        next_s.we_n = 1'b0;
                        next_s.dout = req_wdata;
                        next_s.doe_n = 1'b0;
                        t_value = WR_CYC;
                        next_s.state = S_WR;
                    end else begin
                        next_s.oe_n = 1'b0;
                        t_value = ACC_CYC;
                        next_s.state = S_RD;
                    end
                end
            end
            S_RD, S_PG: begin
                if (t_done) begin
                    next_s.rdata = data_lines_in;
                    next_s.rvalid = 1'b1;
                    if (page_en) begin
                        next_s.state = S_HOLD;
                    end else begin
                        next_s.ce_n = 1'b1;
                        next_s.oe_n = 1'b1;
                        next_s.lb_n = 1'b1;
                        next_s.ub_n = 1'b1;
                        t_load = 1'b1;
                        t_value = GAP_CYC;
                        next_s.state = S_GAP;
                    end
                end
            end
            S_HOLD: begin
                if (pg_take) begin
                    next_s.addr = req_addr;
                    next_s.lb_n = !req_bytes[0];
                    next_s.ub_n = !req_bytes[1];
                    t_load = 1'b1;
                    t_value = PAGE_CYC;
                    next_s.state = S_PG;
                end else if (req || cfg_req || sleep_req || s.ce_cnt >= HOLD_LIMIT) begin
                    // Releasing chip select gives the memory its refresh window.
                    next_s.ce_n = 1'b1;
                    next_s.oe_n = 1'b1;
                    next_s.lb_n = 1'b1;
                    next_s.ub_n = 1'b1;
                    t_load = 1'b1;
                    t_value = GAP_CYC;
                    next_s.state = S_GAP;
                end
            end
            S_WR: begin
                if (t_done) begin
                    // Both strobes rise together while data is still driven.
                    next_s.we_n = 1'b1;
                    next_s.ce_n = 1'b1;
                    next_s.wdone = 1'b1;
                    t_load = 1'b1;
                    t_value = GAP_CYC;
                    next_s.state = S_GAP;
                end
            end
            S_GAP: begin
                next_s.doe_n = 1'b1;
                next_s.lb_n = 1'b1;
                next_s.ub_n = 1'b1;
                if (t_done) begin
                    next_s.state = S_IDLE;
                end
            end
            S_CFG_ZZ: begin
                if (t_done) begin
                    next_s.ce_n = 1'b0;
                    next_s.we_n = 1'b0;
                    t_load = 1'b1;
                    t_value = WR_CYC;
                    next_s.state = S_CFG_WR;
                end
            end
            S_CFG_WR: begin
                if (t_done) begin
                    next_s.ce_n = 1'b1;
                    next_s.we_n = 1'b1;
                    next_s.cfg = s.addr;
                    t_load = 1'b1;
                    t_value = SETUP_CYC;
                    next_s.state = S_CFG_END;
                end
            end
            S_CFG_END: begin
                if (t_done) begin
                    next_s.zz_n = 1'b1;
                    t_load = 1'b1;
                    t_value = GAP_CYC;
                    next_s.state = S_GAP;
                end
            end
            S_SLP_IN: begin
                if (!sleep_req) begin
                    next_s.zz_n = 1'b1;
                    t_load = 1'b1;
                    t_value = GAP_CYC;
                    next_s.state = S_GAP;
                end else if (t_done) begin
                    next_s.state = S_SLEEP;
                end
            end
            S_SLEEP: begin
                if (!sleep_req) begin
                    next_s.zz_n = 1'b1;
                    t_load = 1'b1;
                    // Deep sleep loses state, so the memory reinitialises first.
                    if (!s.cfg[CFG_SLEEP_BIT]) begin
                        t_value = INIT_CYC;
                        next_s.state = S_INIT;
                    end else begin
                        t_value = GAP_CYC;
                        next_s.state = S_GAP;
                    end
                end
            end
            default: begin
                next_s = RESET_ST;
            end
        endcase
        next_s.ce_cnt = next_s.ce_n ? 16'h0000 : sat_inc(s.ce_cnt);
        next_s.zz_cnt = next_s.zz_n ? 16'h0000 : sat_inc(s.zz_cnt);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s <= RESET_ST;
        end else begin
            s <= next_s;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    assign ce_n = s.ce_n;
    assign oe_n = s.oe_n;
    assign we_n = s.we_n;
    assign low_byte_select_n = s.lb_n;
    assign high_byte_select_n = s.ub_n;
    assign sleep_pin_n = s.zz_n;
    assign address_lines = s.addr;
    assign data_lines_out = s.dout;
    assign data_lines_oe_n = s.doe_n;
    assign rdata = s.rdata;
    assign rdata_valid = s.rvalid;
    assign wr_done = s.wdone;
    assign cfg_current = s.cfg;
    assign sleep_active = (s.state == S_SLEEP);
    assign init_busy = (s.state == S_INIT);

    // =====================================================================
    // Assertions
    // =====================================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    read_pins_a: assert property ((s.state == S_RD) |-> !s.ce_n && !s.oe_n && s.we_n && s.zz_n && s.doe_n)
        else $error("read cycle strobes wrong");
    read_wait_a: assert property ($fell(s.oe_n) |=> (!s.oe_n && !s.rvalid)[*8] ##1 s.rvalid)
        else $error("read data taken off the access time");
    write_pins_a: assert property ((s.state == S_WR) |-> !s.ce_n && !s.we_n && s.zz_n && !s.doe_n)
        else $error("write cycle strobes wrong");
    we_pulse_a: assert property ($fell(s.we_n) |-> (!s.we_n)[*7] ##1 $rose(s.we_n))
        else $error("write enable low time wrong");
    ce_limit_a: assert property (s.ce_cnt <= CEM_CYC)
        else $error("chip select low too long");
    cfg_float_a: assert property ((!s.we_n && !s.zz_n) |-> s.doe_n && !s.ce_n)
        else $error("data driven during config load");
    init_select_a: assert property ((s.state == S_INIT) |-> s.ce_n && s.zz_n)
        else $error("chip select low during initialisation");
    sleep_entry_a: assert property ($rose(sleep_active) |-> s.zz_cnt > SLEEP_CYC - 16'h0001)
        else $error("low-power entered too early");
    page_addr_a: assert property ((s.state == S_PG) |-> page_en && (s.addr[19:4] == $past(s.addr[19:4])))
        else $error("page read left the page");

    read_cv: cover property ($rose(s.rvalid) && !page_en);
    page_cv: cover property ((s.state == S_PG) ##[1:10] s.rvalid);
    write_cv: cover property ($rose(s.wdone));
    cfg_cv: cover property ((s.state == S_CFG_END) && s.cfg[CFG_PAGE_BIT]);
    sleep_cv: cover property ($fell(sleep_active) && !s.cfg[CFG_SLEEP_BIT]);

endmodule : psc_host

// ===== design/psc_pkg.sv
// Constants and types shared by the pseudo-static memory host controller.
// Assumes a single 125 MHz clock; every time below is turned into cycles here.
package psc_pkg;

    // =====================================================================
    // Clock and pin timing
    // =====================================================================
    localparam int unsigned CLK_NS = 8;
    localparam int unsigned ACCESS_NS = 70;      // address_access_time, random read.
    localparam int unsigned PAGE_NS = 20;        // Intra-page read access.
    localparam int unsigned WRITE_NS = 55;       // Write enable low pulse.
    localparam int unsigned GAP_NS = 16;         // Chip select high between cycles.
    localparam int unsigned SETUP_NS = 8;        // Sleep pin to chip select setup.
    localparam int unsigned CEM_NS = 4000;       // max_select_low_time.
    localparam int unsigned SLEEP_US = 10;
    localparam int unsigned INIT_US = 150;

    // Least times round up, longest times round down.
    localparam logic [15:0] ACC_CYC = 16'((ACCESS_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] PAGE_CYC = 16'((PAGE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] WR_CYC = 16'((WRITE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] GAP_CYC = 16'((GAP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] SETUP_CYC = 16'((SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] CEM_CYC = 16'(CEM_NS / CLK_NS);
    // Strictly longer than the sleep threshold, hence one extra cycle.
    localparam logic [15:0] SLEEP_CYC = 16'(SLEEP_US * 1000 / CLK_NS + 1);
    localparam int unsigned INIT_CYC_DEF = (INIT_US * 1000 + CLK_NS - 1) / CLK_NS;
    // Page reads stop early enough that chip select rises before the limit.
    localparam logic [15:0] HOLD_LIMIT = 16'(CEM_NS / CLK_NS - (PAGE_NS + CLK_NS - 1) / CLK_NS - 2);

    // =====================================================================
    // Configuration register layout
    // =====================================================================
    localparam int unsigned CFG_W = 20;
    localparam int unsigned CFG_PAGE_BIT = 7;
    localparam int unsigned CFG_SLEEP_BIT = 4;
    localparam logic [19:0] CFG_DEFAULT = 20'h00070;
    localparam int unsigned PAGE_LSB = 4;       // address_lines[3:0] pick a word in the page.

    // =====================================================================
    // Controller states
    // =====================================================================
    typedef enum logic [11:0] {
        S_INIT    = 12'h001,
        S_IDLE    = 12'h002,
        S_RD      = 12'h004,
        S_HOLD    = 12'h008,
        S_PG      = 12'h010,
        S_WR      = 12'h020,
        S_GAP     = 12'h040,
        S_CFG_ZZ  = 12'h080,
        S_CFG_WR  = 12'h100,
        S_CFG_END = 12'h200,
        S_SLP_IN  = 12'h400,
        S_SLEEP   = 12'h800
    } psc_state_t;

endpackage : psc_pkg

// ===== design/psc_timer.sv
// Down-counter that times each phase of a memory cycle.
// Assumes the caller loads a count and waits for done; count N gives N cycles.
`timescale 1ns/10ps
module psc_timer
    import psc_pkg::*;
#(
    parameter logic [15:0] START = 16'h0001
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic load,
    input wire logic [15:0] load_value,
    output logic done
);

    typedef struct packed {
        logic [15:0] count;
    } psc_timer_st_t;

    psc_timer_st_t s;
    psc_timer_st_t next_s;

    // =====================================================================
    // Counter
    // =====================================================================
    // A load wins over the running count so back-to-back phases lose no cycle.
    always_comb begin
        next_s = s;
        if (load) begin
            next_s.count = load_value;
        end else if (s.count != 16'h0000) begin
            next_s.count = s.count - 16'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            s.count <= START;
        end else begin
            s <= next_s;
        end
    end

    // Done in the last cycle of the phase, so the caller moves on exactly on time.
    assign done = (s.count <= 16'h0001);

endmodule : psc_timer

// ===== verif/psc_host_test.sv
// Self-checking bench for psc_host with the memory model on its pins.
// Assumes psc_pkg, psc_host and psc_mem_model are compiled before it.
`timescale 1ns/10ps
module psc_host_test;
    // ==========================================================================
    // Signals
    // ==========================================================================
    localparam logic [15:0] INIT_N = 16'h0014; // Short power-up wait keeps the run brief.
    logic mclk = 1'b0, srst = 1'b1, req = 1'b0, req_write = 1'b0, cfg_req = 1'b0, sleep_req = 1'b0;
    logic [19:0] req_addr = 20'h00000, cfg_value = 20'h00000, cfg_current, address_lines;
    logic [15:0] req_wdata = 16'h0000, rdata, data_lines_out, data_lines_in;
    logic [1:0] req_bytes = 2'h3, mode;
    logic [7:0] viol;
    logic req_ready, rdata_valid, wr_done, sleep_active, init_busy, ce_n, oe_n, we_n;
    logic low_byte_select_n, high_byte_select_n, sleep_pin_n, data_lines_oe_n;
    int bad_count = 0, cmp_count = 0, cycles = 0;

    psc_host #(.INIT_CYC(INIT_N)) dut (.mclk(mclk), .srst(srst), .req(req), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_bytes(req_bytes), .req_ready(req_ready),
        .rdata(rdata), .rdata_valid(rdata_valid), .wr_done(wr_done), .cfg_req(cfg_req),
        .cfg_value(cfg_value), .cfg_current(cfg_current), .sleep_req(sleep_req),
        .sleep_active(sleep_active), .init_busy(init_busy), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .low_byte_select_n(low_byte_select_n), .high_byte_select_n(high_byte_select_n),
        .sleep_pin_n(sleep_pin_n), .address_lines(address_lines), .data_lines_in(data_lines_in),
        .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n));
    psc_mem_model far (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .low_byte_select_n(low_byte_select_n),
        .high_byte_select_n(high_byte_select_n), .sleep_pin_n(sleep_pin_n),
        .address_lines(address_lines), .data_lines_out(data_lines_out),
        .data_lines_oe_n(data_lines_oe_n), .data_lines_in(data_lines_in), .mode(mode), .viol(viol));

    // Clock, and a cycle ceiling that cuts a hang short.
    initial forever #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            test_done();
        end
    end

    // ==========================================================================
    // Shared tasks
    // ==========================================================================
    task automatic check_val(input logic [19:0] got_v, input logic [19:0] exp_v);
        cmp_count++;
        if (got_v !== exp_v) begin
            bad_count++;
            $display("unexpected value at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask : check_val

    // Counts edges until the flag reads as wanted; the bound covers the sleep wait.
    task automatic wait_for(ref logic s, input logic v, output int n);
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (s !== v && n < 3000);
        if (s !== v) bad_count++;
    endtask : wait_for

    // Holds the request until the edge that takes it, then releases it.
    task automatic take(input logic wr, input logic [19:0] a, input logic [15:0] d, input logic [1:0] b);
        int n;
        @(negedge mclk);
        req = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_bytes = b;
        n = 0;
        #1;
        while (req_ready !== 1'b1 && n < 3000) begin
            @(negedge mclk);
            #1;
            n++;
        end
        @(negedge mclk);
        req = 1'b0;
    endtask : take

    task automatic rd(input logic [19:0] a, input logic [1:0] b, output logic [15:0] d, output int n);
        take(1'b0, a, 16'h0000, b);
        wait_for(rdata_valid, 1'b1, n);
        d = rdata;
    endtask : rd

    task automatic wr(input logic [19:0] a, input logic [15:0] d, input logic [1:0] b);
        int n;
        take(1'b1, a, d, b);
        wait_for(wr_done, 1'b1, n);
    endtask : wr

    task automatic cfg_load(input logic [19:0] v);
        int n;
        @(negedge mclk);
        cfg_req = 1'b1;
        cfg_value = v;
        wait_for(sleep_pin_n, 1'b0, n);
        @(negedge mclk);
        cfg_req = 1'b0;
        wait_for(sleep_pin_n, 1'b1, n);
        check_val(cfg_current, v);
    endtask : cfg_load

    // Holds the sleep request until the host reports low power, then wakes it.
    task automatic nap(input logic [1:0] m);
        int n;
        @(negedge mclk);
        sleep_req = 1'b1;
        wait_for(sleep_active, 1'b1, n);
        check_val(20'(mode), 20'(m));
        @(negedge mclk);
        sleep_req = 1'b0;
        wait_for(sleep_pin_n, 1'b1, n);
    endtask : nap

    // ==========================================================================
    // Scenarios
    // ==========================================================================
    task automatic t_reset();
        int n;
        check_val(20'({ce_n, oe_n, we_n, sleep_pin_n, data_lines_oe_n, init_busy}), 20'h0003F);
        check_val(cfg_current, 20'h00070);
        wait_for(init_busy, 1'b0, n);
        check_val(20'(viol), 20'h00000);
        $display("test reset done");
    endtask : t_reset

    // Top-of-array words; page mode is off after power-up, so both reads take full time.
    task automatic t_plain();
        logic [15:0] d;
        int n;
        wr(20'hFFFFF, 16'h1234, 2'h3);
        wr(20'hFFFFE, 16'hABCD, 2'h3);
        rd(20'hFFFFF, 2'h3, d, n);
        check_val(20'(d), 20'h01234);
        rd(20'hFFFFE, 2'h3, d, n);
        check_val(20'(d), 20'h0ABCD);
        check_val(20'(n), 20'(psc_pkg::ACC_CYC));
        $display("test plain done");
    endtask : t_plain

    // Single-lane and no-lane writes must leave the other bytes alone.
    task automatic t_lanes();
        logic [15:0] d;
        int n;
        wr(20'hFFFFF, 16'h55AA, 2'h1);
        wr(20'hFFFFE, 16'h7766, 2'h2);
        wr(20'hFFFFF, 16'h0000, 2'h0);
        rd(20'hFFFFF, 2'h3, d, n);
        check_val(20'(d), 20'h012AA);
        rd(20'hFFFFE, 2'h2, d, n);
        check_val(20'(d[15:8]), 20'h00077);
        $display("test lanes done");
    endtask : t_lanes

    // Page reads: fast within the page, full time once address bit 4 moves.
    task automatic t_page();
        logic [15:0] d;
        int n;
        wr(20'h00100, 16'h1111, 2'h3);
        wr(20'h0010F, 16'h2222, 2'h3);
        wr(20'h00110, 16'h3333, 2'h3);
        cfg_load(20'h000F0);
        rd(20'h00100, 2'h3, d, n);
        rd(20'h0010F, 2'h3, d, n);
        check_val(20'(d), 20'h02222);
        check_val(20'(n), 20'(psc_pkg::PAGE_CYC));
        rd(20'h00110, 2'h3, d, n);
        check_val(20'(d), 20'h03333);
        check_val(20'(n), 20'(psc_pkg::ACC_CYC));
        $display("test page done");
    endtask : t_page

    // Partial refresh keeps data; deep sleep needs a new initialisation on exit.
    task automatic t_sleep();
        logic [15:0] d;
        int n;
        nap(2'h1);
        rd(20'h00100, 2'h3, d, n);
        check_val(20'(d), 20'h01111);
        cfg_load(20'h00060);
        nap(2'h2);
        check_val(20'(init_busy), 20'h00001);
        wr(20'h00200, 16'h4242, 2'h3);
        rd(20'h00200, 2'h3, d, n);
        check_val(20'(d), 20'h04242);
        check_val(20'(viol), 20'h00000);
        $display("test sleep done");
    endtask : t_sleep

    task automatic test_done();
        $display("compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // Main sequence: reset for ten cycles, then each scenario in turn.
    initial begin
        repeat (10) @(negedge mclk);
        srst = 1'b0;
        t_reset();
        t_plain();
        t_lanes();
        t_page();
        t_sleep();
        test_done();
    end
endmodule : psc_host_test

// ===== verif/psc_mem_model.sv
// Behavioural model of the pseudo-static memory that sits on the host pins.
// Assumes the bench wires every host pin to it; all times are in ns.
`timescale 1ns/10ps
module psc_mem_model #(
    parameter real ACC_NS = 70.0,
    parameter real PAGE_NS = 20.0,
    parameter real INIT_NS = 150.0,
    parameter real CEM_NS = 4000.0
) (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic low_byte_select_n,
    input wire logic high_byte_select_n,
    input wire logic sleep_pin_n,
    input wire logic [19:0] address_lines,
    input wire logic [15:0] data_lines_out,
    input wire logic data_lines_oe_n,
    output logic [15:0] data_lines_in,
    output logic [1:0] mode,
    output logic [7:0] viol
);
    // ==========================================================================
    // Storage and timing state
    // ==========================================================================
    logic [15:0] mem [logic [19:0]];
    logic [19:0] cfg = 20'h00070;
    logic tick = 1'b0;
    logic busy = 1'b1;
    logic rd;
    logic [15:0] w;
    real t_full = 0.0, t_pg = 0.0, t_zz = 0.0, t_ce = 0.0, t_we = 0.0, t_init = 0.0;
    wire wact = !ce_n && !we_n && (!sleep_pin_n || !low_byte_select_n || !high_byte_select_n);

    // Pins are resolved once each ns at the half-ns mark so they never change on a clock edge.
    initial begin
        mode = 2'h0;
        viol = 8'h00;
        #0.5;
        forever begin
            #1;
            if (!sleep_pin_n && ce_n && mode == 2'h0 && $realtime - t_zz > 10000.0) begin
                mode = cfg[4] ? 2'h1 : 2'h2;
            end
            busy = mode != 2'h0 || $realtime - t_init < INIT_NS;
            w = mem.exists(address_lines) ? mem[address_lines] : 16'h0000;
            // Data that is not yet valid shows inverted, so an early sample is caught.
            if ($realtime - t_full < ACC_NS || $realtime - t_pg < (cfg[7] ? PAGE_NS : ACC_NS)) begin
                w = ~w;
            end
            rd = !busy && !ce_n && !oe_n && we_n && sleep_pin_n;
            tick = ~tick;
            data_lines_in[7:0] = !data_lines_oe_n ? data_lines_out[7:0] :
                (rd && !low_byte_select_n) ? w[7:0] : (tick ? 8'hA5 : 8'h5A);
            data_lines_in[15:8] = !data_lines_oe_n ? data_lines_out[15:8] :
                (rd && !high_byte_select_n) ? w[15:8] : (tick ? 8'hC3 : 8'h3C);
        end
    end

    // A move above the page restarts the full access; low bits only the page access.
    always @(negedge ce_n or negedge oe_n or address_lines[19:4]) t_full = $realtime;
    always @(address_lines[3:0]) t_pg = $realtime;

    // Strobe length limits and the quiet period after initialisation.
    always @(negedge ce_n) begin
        t_ce = $realtime;
        if ($realtime - t_init < INIT_NS) viol = viol + 8'h01;
    end
    always @(posedge ce_n) if ($realtime - t_ce > CEM_NS) viol = viol + 8'h01;
    always @(negedge we_n) t_we = $realtime;
    always @(posedge we_n) if ($realtime - t_we > CEM_NS) viol = viol + 8'h01;

    // The first rising write strobe stores the word, or loads the config when asleep.
    always @(negedge wact) begin
        if (!sleep_pin_n) begin
            cfg = address_lines;
        end else if (!busy) begin
            w = mem.exists(address_lines) ? mem[address_lines] : 16'h0000;
            if (!low_byte_select_n) w[7:0] = data_lines_in[7:0];
            if (!high_byte_select_n) w[15:8] = data_lines_in[15:8];
            mem[address_lines] = w;
        end
    end

    // Leaving deep sleep loses the array and starts a fresh initialisation.
    always @(negedge sleep_pin_n) t_zz = $realtime;
    always @(posedge sleep_pin_n) begin
        if (mode == 2'h2) begin
            mem.delete();
            t_init = $realtime;
        end
        mode = 2'h0;
    end
endmodule : psc_mem_model
